// ---- rtl/ilx_exec.sv ----
`timescale 1ns/10ps
// Function
// - Decrement complement of AC into index.
// - True index to AC address, rest cleared.
// - True index to AC decrement, rest cleared.
// - Store true index in X address field.
// - Store true index in X decrement field.
// - Instruction address into index, true, I only.
// - Instruction address complement into index, next I.
// - Word X address to index, complement next I.
// - Word X decrement complement into index.
// - Word X address into index, true form.
// - Word X decrement into index, true form.
// - OR of X and AC stored to X.
// - OR into AC, sign and Q kept.
// - AND into AC via complemented OR, I E L.
// - AND into X, I E L E, AC restored.
// - XOR into AC, sign and Q cleared.
// - XOR formed as twice OR minus sum.
// - True index obtained by cycling through adders.
// - Three 15-bit index registers, complemented read-out.
// - Tag bits 18-20 select index registers.
module ilx_exec (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_start,
  input  ilx_pkg::ilx_instr_type       i_instr,
  input  wire logic                    i_ac_load,
  input  ilx_pkg::ilx_ac_type          i_ac_wdata,
  input  wire logic                    i_mem_ack,
  input  wire logic [35:0]             i_mem_rdata,
  output ilx_pkg::ilx_mem_req_type     o_mem,
  output ilx_pkg::ilx_ac_type          o_ac,
  output logic [44:0]                  o_xr_all,
  output ilx_pkg::ilx_cycle_type       o_cycle,
  output logic                         o_busy,
  output logic                         o_done,
  output logic                         o_illegal
);
  import ilx_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_I1,
    S_I2,
    S_RD_WAIT,
    S_L,
    S_WR_WAIT
  } ilx_state_type;

  ilx_state_type     state_r;
  ilx_state_type     state_nxt;
  ilx_instr_type     instr_r;
  ilx_ac_type        ac_r;
  logic [35:0]       sr_r;
  logic              sr_q_r;
  ilx_mem_req_type   mem_r;
  logic [35:0]       wdata_nxt;
  logic              go_rd;
  logic              go_wr;
  logic              finish;
  logic              start_ok;
  logic [11:0]       op;
  logic [2:0]        sel;
  logic              xr_we;
  logic [XR_W-1:0]   xr_wdata;
  logic [XR_W-1:0]   rd_cmp;
  logic [XR_W-1:0]   adder_out;
  logic [35:0]       or_word;
  logic [36:0]       sum_37;
  logic [36:0]       xor_37;

  // The adders take the complemented read-out plus a carry into the low position.
  function automatic logic [XR_W-1:0] ilx_adder(input logic [XR_W-1:0] a, input logic cin);
    ilx_adder = a + {{(XR_W-1){1'b0}}, cin};
  endfunction : ilx_adder

  // Only the two groups of operations handled here are accepted.
  function automatic logic ilx_known(input logic [11:0] code);
    case (code)
      OP_DEC_COMP_TO_XR, OP_PLACE_XR_ADDR, OP_PLACE_XR_DEC, OP_STORE_XR_ADDR,
      OP_STORE_XR_DEC, OP_ADDR_XR_TRUE, OP_ADDR_XR_COMP, OP_LOAD_COMP_ADDR,
      OP_LOAD_COMP_DEC, OP_LOAD_XR_ADDR, OP_LOAD_XR_DEC, OP_OR_TO_MEM,
      OP_OR_INTO_AC, OP_AND_INTO_AC, OP_AND_INTO_MEM, OP_XOR_INTO_AC: ilx_known = 1'b1;
      default: ilx_known = 1'b0;
    endcase
  endfunction : ilx_known

  assign op       = instr_r.op;
  assign start_ok = i_start && (state_r == S_IDLE) && ilx_known(i_instr.op);

  // The tag is taken straight from the instruction in the start cycle, so the
  // read-out is already valid in the first I cycle.
  assign sel       = (state_r == S_IDLE) ? i_instr.tag : instr_r.tag;
  assign adder_out = ilx_adder(rd_cmp, 1'b1);

  ilx_xr_file u_xr_file (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_sel     (sel),
    .i_we      (xr_we),
    .i_wdata   (xr_wdata),
    .o_rd_cmp  (rd_cmp),
    .o_xr_all  (o_xr_all)
  );

  // Exclusive OR with only OR and the adders: 2(A or B) - (A + B).
  assign or_word = ac_r.word | sr_r;
  assign sum_37  = {1'b0, ac_r.word} + {1'b0, sr_r};
  assign xor_37  = {or_word, 1'b0} - sum_37;

  // Sequencing of I, E and L cycles for each operation.
  always_comb begin
    state_nxt = state_r;
    go_rd     = 1'b0;
    go_wr     = 1'b0;
    finish    = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (start_ok) begin
          state_nxt = S_I1;
        end
      end
      S_I1: begin
        case (op)
          OP_ADDR_XR_TRUE: begin
            finish = 1'b1;
          end
          OP_DEC_COMP_TO_XR, OP_PLACE_XR_ADDR, OP_PLACE_XR_DEC,
          OP_STORE_XR_ADDR, OP_STORE_XR_DEC, OP_ADDR_XR_COMP: begin
            state_nxt = S_I2;
          end
          default: begin
            go_rd = 1'b1;
          end
        endcase
      end
      S_I2: begin
        if (op == OP_STORE_XR_ADDR || op == OP_STORE_XR_DEC) begin
          go_rd = 1'b1;
        end else begin
          finish = 1'b1;
        end
      end
      S_RD_WAIT: begin
        if (i_mem_ack) begin
          case (op)
            OP_LOAD_COMP_ADDR, OP_LOAD_COMP_DEC: begin
              state_nxt = S_I2;
            end
            OP_OR_TO_MEM, OP_STORE_XR_ADDR, OP_STORE_XR_DEC: begin
              go_wr = 1'b1;
            end
            OP_AND_INTO_AC, OP_AND_INTO_MEM, OP_XOR_INTO_AC: begin
              state_nxt = S_L;
            end
            default: begin
              finish = 1'b1;
            end
          endcase
        end
      end
      S_L: begin
        if (op == OP_AND_INTO_MEM) begin
          go_wr = 1'b1;
        end else begin
          finish = 1'b1;
        end
      end
      S_WR_WAIT: begin
        if (i_mem_ack) begin
          finish = 1'b1;
        end
      end
      default: begin
        finish = 1'b1;
      end
    endcase
    if (go_rd) begin
      state_nxt = S_RD_WAIT;
    end
    if (go_wr) begin
      state_nxt = S_WR_WAIT;
    end
    if (finish) begin
      state_nxt = S_IDLE;
    end
  end

  // Word written back to storage; stores keep the bits outside their field.
  always_comb begin
    wdata_nxt = sr_r;
    case (op)
      OP_OR_TO_MEM:     wdata_nxt = i_mem_rdata | ac_r.word;
      OP_STORE_XR_ADDR: wdata_nxt = (i_mem_rdata & ~ADDR_MASK) | sr_r;
      OP_STORE_XR_DEC:  wdata_nxt = (i_mem_rdata & ~DEC_MASK) | sr_r;
      OP_AND_INTO_MEM:  wdata_nxt = ~sr_r;
      default:          wdata_nxt = sr_r;
    endcase
  end

  // Index register writes. Each pass through the adders turns the complemented
  // read-out into a two's complement, so two passes give back the true value.
  always_comb begin
    xr_we    = 1'b0;
    xr_wdata = adder_out;
    case (state_r)
      S_I1: begin
        case (op)
          OP_DEC_COMP_TO_XR: begin
            xr_we    = 1'b1;
            xr_wdata = ac_r.word[DEC_LSB +: XR_W];
          end
          OP_PLACE_XR_ADDR, OP_PLACE_XR_DEC, OP_STORE_XR_ADDR, OP_STORE_XR_DEC: begin
            xr_we = 1'b1;
          end
          OP_ADDR_XR_TRUE, OP_ADDR_XR_COMP: begin
            xr_we    = 1'b1;
            xr_wdata = instr_r.addr;
          end
          default: begin
            xr_we = 1'b0;
          end
        endcase
      end
      S_I2: begin
        xr_we = 1'b1;
      end
      S_RD_WAIT: begin
        if (i_mem_ack) begin
          case (op)
            OP_LOAD_COMP_ADDR, OP_LOAD_XR_ADDR: begin
              xr_we    = 1'b1;
              xr_wdata = i_mem_rdata[ADDR_LSB +: XR_W];
            end
            OP_LOAD_COMP_DEC, OP_LOAD_XR_DEC: begin
              xr_we    = 1'b1;
              xr_wdata = i_mem_rdata[DEC_LSB +: XR_W];
            end
            default: begin
              xr_we = 1'b0;
            end
          endcase
        end
      end
      default: begin
        xr_we = 1'b0;
      end
    endcase
  end

  // Sequencer state and the latched instruction.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= S_IDLE;
      instr_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (start_ok) begin
        instr_r <= i_instr;
      end
    end
  end

  // Storage register: holds the shifted index, the complemented OR, or word X.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sr_r   <= SR_RST;
      sr_q_r <= 1'b0;
    end else if (state_r == S_I2 && op == OP_STORE_XR_ADDR) begin
      sr_r <= {{(WORD_W-XR_W){1'b0}}, adder_out};
    end else if (state_r == S_I2 && op == OP_STORE_XR_DEC) begin
      sr_r <= {3'h0, adder_out, 18'h0_0000};
    end else if (state_r == S_RD_WAIT && i_mem_ack) begin
      if (op == OP_AND_INTO_AC || op == OP_AND_INTO_MEM) begin
        sr_r   <= ~i_mem_rdata | ~ac_r.word;
        sr_q_r <= ac_r.q;
      end else begin
        sr_r <= i_mem_rdata;
      end
    end
  end

  // Main arithmetic register. Software loads it only while the datapath is idle.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ac_r <= AC_RST;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (i_ac_load) begin
            ac_r <= i_ac_wdata;
          end
        end
        S_I2: begin
          if (op == OP_PLACE_XR_ADDR) begin
            ac_r <= {2'h0, {(WORD_W-XR_W){1'b0}}, adder_out};
          end else if (op == OP_PLACE_XR_DEC) begin
            ac_r <= {2'h0, 3'h0, adder_out, 18'h0_0000};
          end
        end
        S_RD_WAIT: begin
          if (i_mem_ack && op == OP_OR_INTO_AC) begin
            ac_r.word <= i_mem_rdata | ac_r.word;
          end else if (i_mem_ack && op == OP_AND_INTO_MEM) begin
            ac_r.word <= ~ac_r.word;
            ac_r.q    <= 1'b0;
          end
        end
        S_L: begin
          case (op)
            OP_AND_INTO_AC: begin
              ac_r.word <= ~sr_r;
            end
            OP_AND_INTO_MEM: begin
              ac_r.word <= ~ac_r.word;
              ac_r.q    <= sr_q_r;
            end
            OP_XOR_INTO_AC: begin
              ac_r <= {2'h0, xor_37[35:0]};
            end
            default: begin
              ac_r <= ac_r;
            end
          endcase
        end
        default: begin
          ac_r <= ac_r;
        end
      endcase
    end
  end

  // Storage request is a one-cycle pulse; write data stay until the next write request.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mem_r <= '0;
    end else begin
      mem_r.req <= go_rd | go_wr;
      if (go_rd) begin
        mem_r.we <= 1'b0;
      end else if (go_wr) begin
        mem_r.we    <= 1'b1;
        mem_r.wdata <= wdata_nxt;
      end
    end
  end

  // Status toward the sequencer, registered so it lines up with the state.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_cycle   <= CYC_NONE;
      o_busy    <= 1'b0;
      o_done    <= 1'b0;
      o_illegal <= 1'b0;
    end else begin
      o_busy    <= (state_nxt != S_IDLE);
      o_done    <= finish || (i_start && state_r == S_IDLE && !start_ok);
      o_illegal <= i_start && state_r == S_IDLE && !start_ok;
      case (state_nxt)
        S_I1, S_I2:           o_cycle <= CYC_I;
        S_RD_WAIT, S_WR_WAIT: o_cycle <= CYC_E;
        S_L:                  o_cycle <= CYC_L;
        default:              o_cycle <= CYC_NONE;
      endcase
    end
  end

  assign o_mem = mem_r;
  assign o_ac  = ac_r;

endmodule : ilx_exec

// ---- common/ilx_pkg.sv ----
package ilx_pkg;

  // Datapath widths.
  localparam int XR_W     = 15;
  localparam int NUM_XR   = 3;
  localparam int WORD_W   = 36;

  // Field positions inside a 36-bit word, position S held in bit 35.
  localparam int ADDR_LSB = 0;
  localparam int TAG_LSB  = 15;
  localparam int DEC_LSB  = 18;

  // Field masks used when a store keeps the rest of word X.
  localparam logic [35:0] ADDR_MASK = 36'h0_0000_7FFF;
  localparam logic [35:0] DEC_MASK  = 36'h1_FFFC_0000;

  // Reset values.
  localparam logic [37:0] AC_RST = 38'h00_0000_0000;
  localparam logic [14:0] XR_RST = 15'h0000;
  localparam logic [35:0] SR_RST = 36'h0_0000_0000;

  // Operation codes: sign in bit 11, octal code in bits 10..0.
  localparam logic [11:0] OP_DEC_COMP_TO_XR = 12'h9DF;
  localparam logic [11:0] OP_PLACE_XR_ADDR  = 12'h1EC;
  localparam logic [11:0] OP_PLACE_XR_DEC   = 12'h9EC;
  localparam logic [11:0] OP_STORE_XR_ADDR  = 12'h19C;
  localparam logic [11:0] OP_STORE_XR_DEC   = 12'h99C;
  localparam logic [11:0] OP_ADDR_XR_TRUE   = 12'h1FC;
  localparam logic [11:0] OP_ADDR_XR_COMP   = 12'h9FC;
  localparam logic [11:0] OP_LOAD_COMP_ADDR = 12'h15D;
  localparam logic [11:0] OP_LOAD_COMP_DEC  = 12'h95D;
  localparam logic [11:0] OP_LOAD_XR_ADDR   = 12'h15C;
  localparam logic [11:0] OP_LOAD_XR_DEC    = 12'h95C;
  localparam logic [11:0] OP_OR_TO_MEM      = 12'h982;
  localparam logic [11:0] OP_OR_INTO_AC     = 12'h941;
  localparam logic [11:0] OP_AND_INTO_AC    = 12'h8D0;
  localparam logic [11:0] OP_AND_INTO_MEM   = 12'h0D0;
  localparam logic [11:0] OP_XOR_INTO_AC    = 12'h0D2;

  // Instruction word as it arrives from the sequencer.
  typedef struct packed {
    logic [11:0] op;
    logic [5:0]  spare;
    logic [2:0]  tag;
    logic [14:0] addr;
  } ilx_instr_type;

  // Main arithmetic register: sign, Q, then P and 1-35 as a word.
  typedef struct packed {
    logic        s;
    logic        q;
    logic [35:0] word;
  } ilx_ac_type;

  // One request to core storage.
  typedef struct packed {
    logic        req;
    logic        we;
    logic [35:0] wdata;
  } ilx_mem_req_type;

  // Machine cycle shown to the sequencer.
  typedef enum logic [1:0] {
    CYC_NONE,
    CYC_I,
    CYC_E,
    CYC_L
  } ilx_cycle_type;

endpackage : ilx_pkg

// ---- rtl/ilx_xr_file.sv ----
`timescale 1ns/10ps
module ilx_xr_file (
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_reset_n,
  input  wire logic [ilx_pkg::NUM_XR-1:0]    i_sel,
  input  wire logic                          i_we,
  input  wire logic [ilx_pkg::XR_W-1:0]      i_wdata,
  output logic      [ilx_pkg::XR_W-1:0]      o_rd_cmp,
  output logic      [ilx_pkg::NUM_XR*ilx_pkg::XR_W-1:0] o_xr_all
);
  import ilx_pkg::*;

  logic [NUM_XR-1:0][XR_W-1:0] xr_r;
  logic [NUM_XR-1:0][XR_W-1:0] xr_nxt;
  logic [XR_W-1:0]             sel_or;

  // Each selected register takes the same value on a write.
  generate
    for (genvar g = 0; g < NUM_XR; g++) begin : g_xr
      assign xr_nxt[g] = (i_we && i_sel[g]) ? i_wdata : xr_r[g];
      always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          xr_r[g] <= XR_RST;
        end else begin
          xr_r[g] <= xr_nxt[g];
        end
      end
    end
  endgenerate

  // Selected registers combine by OR; the next values are used so a write is seen at once.
  always_comb begin
    sel_or = '0;
    for (int k = 0; k < NUM_XR; k++) begin
      if (i_sel[k]) begin
        sel_or = sel_or | xr_nxt[k];
      end
    end
  end

  // Read-out toward the adders is always complemented.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_cmp <= ~XR_RST;
      o_xr_all <= '0;
    end else begin
      o_rd_cmp <= ~sel_or;
      o_xr_all <= xr_nxt;
    end
  end

endmodule : ilx_xr_file

// ---- verification/ilx_exec_asserts.sv ----
`timescale 1ns/10ps
module ilx_exec_asserts
  import ilx_pkg::*;
(
  input wire logic                i_sys_clk,
  input wire logic                i_reset_n,
  input wire logic                i_start,
  input ilx_pkg::ilx_instr_type   i_instr,
  input wire logic                i_ac_load,
  input ilx_pkg::ilx_ac_type      i_ac_wdata,
  input wire logic                i_mem_ack,
  input wire logic [35:0]         i_mem_rdata,
  input ilx_pkg::ilx_mem_req_type o_mem,
  input ilx_pkg::ilx_ac_type      o_ac,
  input wire logic [44:0]         o_xr_all,
  input ilx_pkg::ilx_cycle_type   o_cycle,
  input wire logic                o_busy,
  input wire logic                o_done,
  input wire logic                o_illegal
);
  // All checks share the one clock; reset silences them.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  // A start counts only when the block is idle, as busy starts are ignored.
  logic       go;
  logic [2:0] tg;
  assign go = i_start && !o_busy;
  assign tg = i_instr.tag;

  a_addr_true_timing:
    assert property (go && i_instr.op == OP_ADDR_XR_TRUE |=> o_cycle == CYC_I ##1 o_done)
    else $error("Address load did not end after one I cycle.");
  a_addr_true_value:
    assert property (go && i_instr.op == OP_ADDR_XR_TRUE && tg[0]
      |-> ##2 o_xr_all[14:0] == $past(i_instr.addr, 2))
    else $error("Index register did not receive the address.");
  a_all_regs_loaded:
    assert property (go && i_instr.op == OP_ADDR_XR_TRUE && tg == 3'h7
      |-> ##2 o_xr_all == {3{$past(i_instr.addr, 2)}})
    else $error("Not every selected index register was written.");
  a_addr_comp_value:
    assert property (go && i_instr.op == OP_ADDR_XR_COMP && tg[0]
      |-> ##3 o_xr_all[14:0] == 15'h0 - $past(i_instr.addr, 3))
    else $error("Complemented address load is wrong.");
  a_dec_comp_value:
    assert property (go && i_instr.op == OP_DEC_COMP_TO_XR && tg == 3'h1
      |-> ##3 o_ac == $past(o_ac, 2) && o_xr_all[14:0] == 15'h0 - o_ac.word[32:18])
    else $error("Decrement complement load is wrong.");
  a_place_addr_value:
    assert property (go && i_instr.op == OP_PLACE_XR_ADDR && tg == 3'h1
      |-> ##3 o_done && o_ac == {23'h0, o_xr_all[14:0]} && o_xr_all == $past(o_xr_all, 3))
    else $error("Index to address field is wrong.");
  a_place_dec_value:
    assert property (go && i_instr.op == OP_PLACE_XR_DEC && tg == 3'h1
      |-> ##3 o_done && o_ac == {5'h0, o_xr_all[14:0], 18'h0})
    else $error("Index to decrement field is wrong.");
  a_req_in_e:
    assert property (o_mem.req |-> o_busy && o_cycle == CYC_E)
    else $error("Storage request outside an E cycle.");

  // Main scenarios reached.
  c_and_mem: cover property (go && i_instr.op == OP_AND_INTO_MEM);
  c_mem_wr:  cover property (o_mem.req && o_mem.we);
  c_all_sel: cover property (go && tg == 3'h7);
endmodule : ilx_exec_asserts

bind ilx_exec ilx_exec_asserts u_ilx_exec_asserts (
  .i_sys_clk, .i_reset_n, .i_start, .i_instr, .i_ac_load, .i_ac_wdata, .i_mem_ack,
  .i_mem_rdata, .o_mem, .o_ac, .o_xr_all, .o_cycle, .o_busy, .o_done, .o_illegal
);

// ---- verification/ilx_mem_model.sv ----
`timescale 1ns/10ps
module ilx_mem_model
  import ilx_pkg::*;
(
  input  wire logic                i_sys_clk,
  input  wire logic                i_reset_n,
  input  ilx_pkg::ilx_mem_req_type i_mem,
  input  wire logic [2:0]          i_delay,
  input  wire logic                i_init,
  input  wire logic [35:0]         i_init_word,
  output logic                     o_ack,
  output logic [35:0]              o_rdata,
  output logic [35:0]              o_word
);
  logic        pend_r;
  logic [2:0]  cnt_r;
  logic        we_r;
  logic [35:0] wd_r;

  // Word X, one request at a time, answered i_delay cycles late.
  // Read data toggles outside the answer so stale data never passes.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_r  <= 1'b0;
      cnt_r   <= 3'h0;
      we_r    <= 1'b0;
      wd_r    <= 36'h0;
      o_ack   <= 1'b0;
      o_rdata <= 36'h0;
      o_word  <= 36'h0;
    end else begin
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_init) begin
        o_word <= i_init_word;
      end
      if (i_mem.req) begin
        pend_r <= 1'b1;
        cnt_r  <= i_delay;
        we_r   <= i_mem.we;
        wd_r   <= i_mem.wdata;
      end else if (pend_r && cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end else if (pend_r) begin
        pend_r  <= 1'b0;
        o_ack   <= 1'b1;
        o_rdata <= o_word;
        if (we_r) begin
          o_word <= wd_r;
        end
      end
    end
  end
endmodule : ilx_mem_model

// ---- verification/ilx_exec_tb.sv ----
`timescale 1ns/10ps
module ilx_exec_tb;
  import ilx_pkg::*;

  typedef struct packed {
    logic [11:0] op;
    logic [2:0]  dly;
  } ilx_row_type;

  localparam logic [14:0] ADDR = 15'h5A3C;
  localparam logic [37:0] AC_V = 38'h2D_96A5_C3F0;
  localparam logic [35:0] X_V  = 36'h5_3C96_A1F7;

  logic            i_sys_clk;
  logic            i_reset_n;
  logic            i_start;
  ilx_instr_type   i_instr;
  logic            i_ac_load;
  ilx_ac_type      i_ac_wdata;
  logic            i_mem_ack;
  logic [35:0]     i_mem_rdata;
  ilx_mem_req_type o_mem;
  ilx_ac_type      o_ac;
  logic [44:0]     o_xr_all;
  ilx_cycle_type   o_cycle;
  logic            o_busy;
  logic            o_done;
  logic            o_illegal;
  logic [2:0]      dly;
  logic            init;
  logic [35:0]     x_word;
  logic [14:0]     xr_m;
  logic [14:0]     e_xr;
  logic [37:0]     e_ac;
  logic [35:0]     e_x;
  int              err_count;
  int              n_compared;

  // Every opcode once; delay 0 answers promptly, 3 stalls storage.
  ilx_row_type rows [16] = '{
    '{OP_ADDR_XR_TRUE, 3'h0}, '{OP_PLACE_XR_ADDR, 3'h0}, '{OP_PLACE_XR_DEC, 3'h0},
    '{OP_STORE_XR_ADDR, 3'h3}, '{OP_STORE_XR_DEC, 3'h0}, '{OP_ADDR_XR_COMP, 3'h0},
    '{OP_DEC_COMP_TO_XR, 3'h0}, '{OP_LOAD_COMP_ADDR, 3'h3}, '{OP_LOAD_COMP_DEC, 3'h0},
    '{OP_LOAD_XR_ADDR, 3'h0}, '{OP_LOAD_XR_DEC, 3'h3}, '{OP_OR_TO_MEM, 3'h0},
    '{OP_OR_INTO_AC, 3'h3}, '{OP_AND_INTO_AC, 3'h0}, '{OP_AND_INTO_MEM, 3'h3},
    '{OP_XOR_INTO_AC, 3'h0}};

  ilx_exec u_ilx_exec (
    .i_sys_clk, .i_reset_n, .i_start, .i_instr, .i_ac_load, .i_ac_wdata, .i_mem_ack,
    .i_mem_rdata, .o_mem, .o_ac, .o_xr_all, .o_cycle, .o_busy, .o_done, .o_illegal
  );

  ilx_mem_model u_ilx_mem_model (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_mem(o_mem), .i_delay(dly),
    .i_init(init), .i_init_word(X_V), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata),
    .o_word(x_word)
  );

  // Free-running 40 MHz clock.
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  task automatic final_report();
    if (err_count == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [44:0] seen, input logic [44:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Pulses start for one cycle; inputs move 1 ns after the edge.
  task automatic kick(input logic [11:0] op, input logic [2:0] tg, input logic [14:0] ad);
    i_start = 1'b1;
    i_instr = {op, 6'h0, tg, ad};
    @(posedge i_sys_clk);
    #1;
    i_start = 1'b0;
  endtask : kick

  // Bounded wait, so a hung instruction ends the run instead of stalling it.
  task automatic run(input logic [11:0] op, input logic [2:0] tg, input logic [14:0] ad);
    int n;
    n = 0;
    kick(op, tg, ad);
    while (o_done !== 1'b1 && n < 60) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (n == 60) begin
      err_count++;
      $display("MISMATCH at %0t: instruction never completed", $time);
      final_report();
    end
  endtask : run

  // Main sequence: reset, table of opcodes, then the awkward cases.
  initial begin
    err_count  = 0;
    n_compared = 0;
    i_reset_n  = 1'b0;
    i_start    = 1'b0;
    i_instr    = 36'h0;
    i_ac_load  = 1'b0;
    i_ac_wdata = 38'h0;
    dly        = 3'h0;
    init       = 1'b0;
    xr_m       = 15'h0;
    repeat (12) @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b1;
    foreach (rows[i]) begin
      @(posedge i_sys_clk);
      #1;
      i_ac_load  = 1'b1;
      i_ac_wdata = AC_V;
      init       = 1'b1;
      dly        = rows[i].dly;
      @(posedge i_sys_clk);
      #1;
      i_ac_load = 1'b0;
      init      = 1'b0;
      e_ac      = AC_V;
      e_x       = X_V;
      e_xr      = xr_m;
      case (rows[i].op)
        OP_DEC_COMP_TO_XR: e_xr = 15'h0 - AC_V[32:18];
        OP_PLACE_XR_ADDR:  e_ac = {23'h0, xr_m};
        OP_PLACE_XR_DEC:   e_ac = {5'h0, xr_m, 18'h0};
        OP_STORE_XR_ADDR:  e_x = (X_V & ~ADDR_MASK) | {21'h0, xr_m};
        OP_STORE_XR_DEC:   e_x = (X_V & ~DEC_MASK) | {3'h0, xr_m, 18'h0};
        OP_ADDR_XR_TRUE:   e_xr = ADDR;
        OP_ADDR_XR_COMP:   e_xr = 15'h0 - ADDR;
        OP_LOAD_COMP_ADDR: e_xr = 15'h0 - X_V[14:0];
        OP_LOAD_COMP_DEC:  e_xr = 15'h0 - X_V[32:18];
        OP_LOAD_XR_ADDR:   e_xr = X_V[14:0];
        OP_LOAD_XR_DEC:    e_xr = X_V[32:18];
        OP_OR_TO_MEM:      e_x = X_V | AC_V[35:0];
        OP_OR_INTO_AC:     e_ac[35:0] = AC_V[35:0] | X_V;
        OP_AND_INTO_AC:    e_ac[35:0] = AC_V[35:0] & X_V;
        OP_AND_INTO_MEM:   e_x = X_V & AC_V[35:0];
        default:           e_ac = {2'h0, AC_V[35:0] ^ X_V};
      endcase
      run(rows[i].op, 3'h1, ADDR);
      chk(45'(o_ac), 45'(e_ac));
      chk(45'(o_xr_all[14:0]), 45'(e_xr));
      chk(45'(x_word), 45'(e_x));
      xr_m = e_xr;
    end
    // One tag loads all three, then a single tag touches only its own.
    @(posedge i_sys_clk);
    #1;
    run(OP_ADDR_XR_TRUE, 3'h7, ADDR);
    chk(o_xr_all, {3{ADDR}});
    @(posedge i_sys_clk);
    #1;
    run(OP_ADDR_XR_COMP, 3'h4, 15'h0001);
    chk(o_xr_all, {15'h7FFF, ADDR, ADDR});
    // Reset in the middle of a stalled read-modify-write clears the state.
    @(posedge i_sys_clk);
    #1;
    dly = 3'h3;
    kick(OP_AND_INTO_MEM, 3'h1, ADDR);
    repeat (3) @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b0;
    #2;
    chk({o_xr_all[29:0], o_ac[14:0]}, 45'h0);
    chk(45'({o_busy, o_done, o_cycle}), 45'h0);
    @(posedge i_sys_clk);
    #1;
    i_reset_n = 1'b1;
    // The block must work again at once, and an unknown code must leave the registers alone.
    run(OP_ADDR_XR_TRUE, 3'h2, ADDR);
    chk(o_xr_all, {15'h0, ADDR, 15'h0});
    @(posedge i_sys_clk);
    #1;
    run(12'h000, 3'h1, ADDR);
    chk(45'({o_illegal, o_busy}), 45'h2);
    chk(o_xr_all, {15'h0, ADDR, 15'h0});
    final_report();
  end
endmodule : ilx_exec_tb
